//--- fwec_params.svh
// constants for the flash write/erase controller
`ifndef FWEC_PARAMS_SVH
`define FWEC_PARAMS_SVH
`define FWEC_ADDR_PSC        8'h8f
`define FWEC_ADDR_PAGE       8'haa
`define FWEC_ADDR_SCALE      8'hb6
`define FWEC_ADDR_KEY        8'hb7
`define FWEC_ADDR_CMD        8'hc0
`define FWEC_ADDR_ADDR_LO    8'hc1
`define FWEC_ADDR_ADDR_HI    8'hc2
`define FWEC_ADDR_WDATA      8'hc3
`define FWEC_ADDR_STATUS     8'hc4
`define FWEC_ADDR_RDATA      8'hc5
`define FWEC_KEY_FIRST       8'ha5
`define FWEC_KEY_SECOND      8'hf1
`define FWEC_SCALE_RESET     8'h80
`define FWEC_SCALE_OSE_BIT   7
`define FWEC_PSC_WE_BIT      0
`define FWEC_PSC_EE_BIT      1
`define FWEC_CMD_GO_BIT      0
`define FWEC_CMD_RD_BIT      1
`define FWEC_CMD_MODE8_BIT   2
`define FWEC_RAM_AW          10
`define FWEC_RAM_DEPTH       1024
`define FWEC_FLASH_AW        14
`define FWEC_FLASH_DEPTH     16384
`define FWEC_PAGE_AW         9
`define FWEC_WRITE_CYCLES    4
`define FWEC_ERASE_CYCLES    16
`endif

//--- fwec_pkg.sv
// types for the flash write/erase controller
package fwec_pkg;
   typedef enum logic [1:0] {
      FWEC_LOCKED   = 2'h0,
      FWEC_KEY1     = 2'h1,
      FWEC_UNLOCKED = 2'h2,
      FWEC_DEAD     = 2'h3
   } fwec_lock_t;
endpackage

//--- fwec_if.sv
// external-move bus and register port between core and flash controller
`timescale 1ns/1ns
interface fwec_if;
   logic        req;
   logic        wr;
   logic        rd;
   logic        sfr;
   logic [15:0] addr;
   logic [7:0]  wdata;
   logic [7:0]  rdata;
   logic        stall;
   logic        done;
   logic        oneshot_en;
   modport core (output req, wr, rd, sfr, addr, wdata, input rdata, stall, done, oneshot_en);
   modport dev  (input req, wr, rd, sfr, addr, wdata, output rdata, stall, done, oneshot_en);
endinterface

//--- fwec_device.sv
// flash write/erase controller with data RAM
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ns
`include "fwec_params.svh"
module fwec_device (
   // clock and reset
   input  wire logic   clk,
   input  wire logic   rst_n,
   // core side
   fwec_if.dev         bus,
   // status to system
   output fwec_pkg::fwec_lock_t lock_state,
   output logic        flash_busy
);
   import fwec_pkg::*;
   logic [7:0]  ram   [0:`FWEC_RAM_DEPTH-1];
   logic [7:0]  flash [0:`FWEC_FLASH_DEPTH-1];
   logic [1:0]  psc_q;
   logic [1:0]  page_q;
   logic        ose_q;
   fwec_lock_t  lock_q;
   logic [4:0]  cnt_q;
   logic        busy_q;
   logic        erase_q;
   logic [15:0] op_addr_q;
   logic [7:0]  op_data_q;
   logic [7:0]  rdata_q;
   logic        done_q;
   logic        is_wr_flash;
   logic        is_wr_ram;
   logic        take;
   assign take        = bus.req && !busy_q && !done_q;
   assign is_wr_flash = take && !bus.sfr && bus.wr && psc_q[`FWEC_PSC_WE_BIT];
   assign is_wr_ram   = take && !bus.sfr && bus.wr && !psc_q[`FWEC_PSC_WE_BIT];
   // registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         psc_q  <= 2'h0;
         page_q <= 2'h0;
         ose_q  <= 1'b1;
      end else if (take && bus.sfr && bus.wr) begin
         case (bus.addr[7:0])
            `FWEC_ADDR_PSC:   psc_q  <= bus.wdata[1:0];
            `FWEC_ADDR_PAGE:  page_q <= bus.wdata[1:0];
            `FWEC_ADDR_SCALE: ose_q  <= bus.wdata[`FWEC_SCALE_OSE_BIT];
            default: ;
         endcase
      end
   end
   // lock state machine
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_q <= FWEC_LOCKED;
      end else if (take && bus.sfr && bus.wr && bus.addr[7:0] == `FWEC_ADDR_KEY) begin
         case (lock_q)
            FWEC_LOCKED:   lock_q <= (bus.wdata == `FWEC_KEY_FIRST) ? FWEC_KEY1 : FWEC_DEAD;
            FWEC_KEY1:     lock_q <= (bus.wdata == `FWEC_KEY_SECOND) ? FWEC_UNLOCKED : FWEC_DEAD;
            FWEC_UNLOCKED: lock_q <= FWEC_DEAD;
            default:       lock_q <= FWEC_DEAD;
         endcase
      end else if (is_wr_flash) begin
         lock_q <= (lock_q == FWEC_UNLOCKED) ? FWEC_LOCKED : FWEC_DEAD;
      end
   end
   // flash operation sequencer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q    <= 1'b0;
         erase_q   <= 1'b0;
         cnt_q     <= 5'h0;
         op_addr_q <= 16'h0;
         op_data_q <= 8'h0;
      end else if (is_wr_flash && lock_q == FWEC_UNLOCKED) begin
         busy_q    <= 1'b1;
         erase_q   <= psc_q[`FWEC_PSC_EE_BIT];
         cnt_q     <= psc_q[`FWEC_PSC_EE_BIT] ? 5'(`FWEC_ERASE_CYCLES) : 5'(`FWEC_WRITE_CYCLES);
         op_addr_q <= bus.addr;
         op_data_q <= bus.wdata;
      end else if (busy_q) begin
         cnt_q <= cnt_q - 5'h1;
         if (cnt_q == 5'h1) begin
            busy_q <= 1'b0;
         end
      end
   end
   // flash array; erase wipes the page, byte write only clears bits
   always_ff @(posedge clk) begin
      if (busy_q && cnt_q == 5'h1) begin
         if (erase_q) begin
            for (int i = 0; i < (1 << `FWEC_PAGE_AW); i++) begin
               flash[{op_addr_q[`FWEC_FLASH_AW-1:`FWEC_PAGE_AW], `FWEC_PAGE_AW'(i)}] <= 8'hff;
            end
         end else begin
            flash[op_addr_q[`FWEC_FLASH_AW-1:0]] <= flash[op_addr_q[`FWEC_FLASH_AW-1:0]] & op_data_q;
         end
      end
   end
   // data RAM address: pointer mode ignores top bits, 8-bit mode uses page field
   function automatic logic [`FWEC_RAM_AW-1:0] ram_index(input logic [15:0] a, input logic [1:0] pg,
                                                          input logic mode8);
      ram_index = mode8 ? {pg, a[7:0]} : a[`FWEC_RAM_AW-1:0];
   endfunction
   always_ff @(posedge clk) begin
      if (is_wr_ram) begin
         ram[ram_index(bus.addr, page_q, bus.rd)] <= bus.wdata;
      end
   end
   // read data and completion pulse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 8'h0;
         done_q  <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (take && !(is_wr_flash && lock_q == FWEC_UNLOCKED)) begin
            done_q <= 1'b1;
            if (bus.sfr && !bus.wr) begin
               case (bus.addr[7:0])
                  `FWEC_ADDR_PSC:   rdata_q <= {6'h0, psc_q};
                  `FWEC_ADDR_PAGE:  rdata_q <= {6'h0, page_q};
                  `FWEC_ADDR_SCALE: rdata_q <= {ose_q, 7'h0};
                  `FWEC_ADDR_KEY:   rdata_q <= {6'h0, lock_q};
                  default:          rdata_q <= 8'h0;
               endcase
            end else if (!bus.wr) begin
               rdata_q <= ram[ram_index(bus.addr, page_q, bus.rd)];
            end
         end else if (busy_q && cnt_q == 5'h1) begin
            done_q <= 1'b1;
         end
      end
   end
   assign bus.rdata      = rdata_q;
   assign bus.done       = done_q;
   assign bus.stall      = busy_q;
   assign bus.oneshot_en = ose_q;
   assign lock_state     = lock_q;
   assign flash_busy     = busy_q;
endmodule // fwec_device

//--- fwec_core.sv
// core end: Avalon-MM slave turning software orders into external-move accesses
`timescale 1ns/1ns
`include "fwec_params.svh"
module fwec_core (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // avalon slave
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [7:0]  avs_writedata,
   output logic [7:0]       avs_readdata,
   output logic             avs_waitrequest,
   // device link
   fwec_if.core             bus
);
   import fwec_pkg::*;
   logic [15:0] addr_q;
   logic [7:0]  wdata_q;
   logic [7:0]  rdata_q;
   logic        req_q, wr_q, rd_q, sfr_q, busy_q, pend_q;
   logic [7:0]  ard_q;
   logic        ack_q;
   logic        run;
   // software go bit or direct register pass-through
   assign run = (avs_write || avs_read) && !pend_q && !ack_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_q <= 16'h0; wdata_q <= 8'h0; rdata_q <= 8'h0;
         req_q <= 1'b0; wr_q <= 1'b0; rd_q <= 1'b0; sfr_q <= 1'b0;
         busy_q <= 1'b0; pend_q <= 1'b0; ard_q <= 8'h0; ack_q <= 1'b0;
      end else begin
         ack_q <= 1'b0;
         req_q <= 1'b0;
         if (run) begin
            case (avs_address)
               `FWEC_ADDR_ADDR_LO: begin addr_q[7:0]  <= avs_writedata; ard_q <= addr_q[7:0];  ack_q <= 1'b1; end
               `FWEC_ADDR_ADDR_HI: begin addr_q[15:8] <= avs_writedata; ard_q <= addr_q[15:8]; ack_q <= 1'b1; end
               `FWEC_ADDR_WDATA:   begin wdata_q <= avs_writedata; ard_q <= wdata_q; ack_q <= 1'b1; end
               `FWEC_ADDR_STATUS:  begin ard_q <= {7'h0, busy_q}; ack_q <= 1'b1; end
               `FWEC_ADDR_RDATA:   begin ard_q <= rdata_q; ack_q <= 1'b1; end
               `FWEC_ADDR_CMD: begin
                  if (avs_write && avs_writedata[`FWEC_CMD_GO_BIT]) begin
                     req_q  <= 1'b1; pend_q <= 1'b1; busy_q <= 1'b1; sfr_q <= 1'b0;
                     wr_q   <= !avs_writedata[`FWEC_CMD_RD_BIT];
                     rd_q   <= avs_writedata[`FWEC_CMD_MODE8_BIT];
                  end else begin
                     ard_q <= 8'h0; ack_q <= 1'b1;
                  end
               end
               `FWEC_ADDR_PSC, `FWEC_ADDR_PAGE, `FWEC_ADDR_SCALE, `FWEC_ADDR_KEY: begin
                  req_q <= 1'b1; pend_q <= 1'b1; sfr_q <= 1'b1; wr_q <= avs_write; rd_q <= 1'b0;
                  addr_q[7:0] <= avs_address; wdata_q <= avs_writedata;
               end
               default: begin ard_q <= 8'h0; ack_q <= 1'b1; end
            endcase
         end else if (pend_q && bus.done) begin
            pend_q  <= 1'b0; busy_q <= 1'b0; ack_q <= 1'b1;
            rdata_q <= bus.rdata; ard_q <= bus.rdata;
         end else if (pend_q && !bus.stall && !req_q) begin
            req_q <= 1'b0;
         end
      end
   end
   assign avs_waitrequest = !ack_q;
   assign avs_readdata    = ard_q;
   assign bus.req   = req_q;
   assign bus.wr    = wr_q;
   assign bus.rd    = rd_q;
   assign bus.sfr   = sfr_q;
   assign bus.addr  = addr_q;
   assign bus.wdata = wdata_q;
endmodule // fwec_core

//--- fwec_link_properties.sv
// concurrent checks on the link between core end and device end
`timescale 1ns/1ns
`include "fwec_params.svh"
module fwec_link_properties (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // link signals
   input wire logic        req,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic        sfr,
   input wire logic [15:0] addr,
   input wire logic [7:0]  wdata,
   input wire logic [7:0]  rdata,
   input wire logic        stall,
   input wire logic        done,
   input wire logic        oneshot_en
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_read_done: assert property (req && !wr |=> done)
      else $error("link read not answered next cycle");
   a_scale_low: assert property (req && sfr && !wr && addr[7:0] == `FWEC_ADDR_SCALE |=> rdata[6:0] == 7'h00)
      else $error("scale low bits not zero");
   a_psc_upper: assert property (req && sfr && !wr && addr[7:0] == `FWEC_ADDR_PSC |=> rdata[7:2] == 6'h00)
      else $error("control upper bits not zero");
   a_page_upper: assert property (req && sfr && !wr && addr[7:0] == `FWEC_ADDR_PAGE |=> rdata[7:2] == 6'h00)
      else $error("page register upper bits not zero");
   a_oneshot_on: assert property (req && sfr && wr && addr[7:0] == `FWEC_ADDR_SCALE && wdata[7] |-> ##[1:3] oneshot_en)
      else $error("one-shot enable not set");
   a_oneshot_off: assert property (req && sfr && wr && addr[7:0] == `FWEC_ADDR_SCALE && !wdata[7] |-> ##[1:3] !oneshot_en)
      else $error("one-shot enable not cleared");
   a_oneshot_rst: assert property ($rose(rst_n) |-> oneshot_en)
      else $error("one-shot enable not set after reset");
   a_stall_bound: assert property ($rose(stall) |-> ##[1:40] !stall)
      else $error("stall longer than a flash operation");
   a_done_pulse: assert property (done |=> !done)
      else $error("done longer than one cycle");
endmodule // fwec_link_properties

//--- flash_write_erase_control_tb_top.sv
// self-checking bench for the flash write/erase controller
`timescale 1ns/1ns
`include "fwec_params.svh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin \
   $display("BAD %s exp %h got %h", n, e, g); n_errors++; end end
module flash_write_erase_control_tb_top;
   import fwec_pkg::*;
   logic       clk;
   logic       rst_n;
   logic [7:0] av_addr;
   logic       av_rd;
   logic       av_wr;
   logic [7:0] av_wd;
   logic [7:0] av_rdata;
   logic       av_wait;
   logic [7:0] rv;
   fwec_lock_t lk;
   logic       busy;
   int         n_errors;
   int         n_checks;
   int         n_busy;
   fwec_if link ();
   fwec_core fwec_core_inst (.clk(clk), .rst_n(rst_n), .avs_address(av_addr), .avs_read(av_rd),
      .avs_write(av_wr), .avs_writedata(av_wd), .avs_readdata(av_rdata), .avs_waitrequest(av_wait), .bus(link.core));
   fwec_device fwec_device_inst (.clk(clk), .rst_n(rst_n), .bus(link.dev), .lock_state(lk), .flash_busy(busy));
   fwec_link_properties fwec_link_properties_inst (.clk(clk), .rst_n(rst_n), .req(link.req), .wr(link.wr),
      .rd(link.rd), .sfr(link.sfr), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .stall(link.stall),
      .done(link.done), .oneshot_en(link.oneshot_en));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk; // one clock source kept through flash operations
   end
   // counts edges at which the device reports a flash operation in progress
   always @(posedge clk) begin
      n_busy <= rst_n ? n_busy + int'(busy === 1'b1) : 0;
   end
   task final_report;
      if (n_errors == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task rst;
      rst_n <= 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
   endtask
   task av(input logic w, input logic [7:0] a, input logic [7:0] d);
      int i;
      @(posedge clk);
      av_addr <= a;
      av_wd <= d;
      av_wr <= w;
      av_rd <= !w;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (av_wait !== 1'b0 && i < 300);
      rv = av_rdata;
      av_wr <= 1'b0;
      av_rd <= 1'b0;
      if (i >= 300) begin
         n_errors++;
         final_report;
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      av(1'b1, a, d);
   endtask
   task ck(input logic [7:0] a, input logic [7:0] e);
      av(1'b0, a, 8'h00);
      `CHK($sformatf("reg %h", a), e, rv)
   endtask
   task mv(input logic [15:0] a, input logic [7:0] d, input logic [7:0] cmd);
      wr(`FWEC_ADDR_ADDR_LO, a[7:0]);
      wr(`FWEC_ADDR_ADDR_HI, a[15:8]);
      wr(`FWEC_ADDR_WDATA, d);
      wr(`FWEC_ADDR_CMD, cmd);
   endtask
   task mvr(input logic [15:0] a, input logic [7:0] cmd, input logic [7:0] e);
      mv(a, 8'h00, cmd);
      ck(`FWEC_ADDR_RDATA, e);
   endtask
   initial begin
      rst_n = 1'b0;
      av_addr = 8'h00;
      av_rd = 1'b0;
      av_wr = 1'b0;
      av_wd = 8'h00;
      n_errors = 0;
      n_checks = 0;
      rst;
      ck(`FWEC_ADDR_PSC, 8'h00);
      ck(`FWEC_ADDR_PAGE, 8'h00);
      ck(`FWEC_ADDR_SCALE, `FWEC_SCALE_RESET);
      ck(`FWEC_ADDR_KEY, 8'h00);
      ck(8'h10, 8'h00);
      wr(`FWEC_ADDR_PSC, 8'hff);
      ck(`FWEC_ADDR_PSC, 8'h03);
      wr(`FWEC_ADDR_PSC, 8'h00);
      wr(`FWEC_ADDR_PAGE, 8'hff);
      ck(`FWEC_ADDR_PAGE, 8'h03);
      wr(`FWEC_ADDR_SCALE, 8'h00);
      ck(`FWEC_ADDR_SCALE, 8'h00);
      `CHK("oneshot", 1'b0, link.oneshot_en)
      wr(`FWEC_ADDR_SCALE, 8'h80);
      mv(16'h0012, 8'h5a, 8'h01);
      mvr(16'h0412, 8'h03, 8'h5a);
      mvr(16'hfc12, 8'h03, 8'h5a);
      wr(`FWEC_ADDR_PAGE, 8'h01);
      mv(16'hff34, 8'h3c, 8'h05);
      mvr(16'h0134, 8'h03, 8'h3c);
      mvr(16'h0034, 8'h07, 8'h3c);
      mv(16'h0200, 8'h77, 8'h01);
      mv(16'h0201, 8'h66, 8'h01);
      wr(`FWEC_ADDR_PSC, 8'h03);
      wr(`FWEC_ADDR_KEY, `FWEC_KEY_FIRST);
      ck(`FWEC_ADDR_KEY, 8'h01);
      wr(`FWEC_ADDR_KEY, `FWEC_KEY_SECOND);
      ck(`FWEC_ADDR_KEY, 8'h02);
      mv(16'h0200, 8'h00, 8'h01);
      `CHK("flash erase lo", 8'hff, fwec_device_inst.flash[14'h0200])
      `CHK("flash erase hi", 8'hff, fwec_device_inst.flash[14'h03ff])
      `CHK("busy cycles", `FWEC_ERASE_CYCLES, n_busy)
      ck(`FWEC_ADDR_KEY, 8'h00);
      wr(`FWEC_ADDR_PSC, 8'h01);
      wr(`FWEC_ADDR_KEY, `FWEC_KEY_FIRST);
      wr(`FWEC_ADDR_KEY, `FWEC_KEY_SECOND);
      mv(16'h0201, 8'h12, 8'h01);
      ck(`FWEC_ADDR_KEY, 8'h00);
      `CHK("flash byte", 8'h12, fwec_device_inst.flash[14'h0201])
      `CHK("busy cycles", `FWEC_ERASE_CYCLES + `FWEC_WRITE_CYCLES, n_busy)
      wr(`FWEC_ADDR_PSC, 8'h00);
      mvr(16'h0200, 8'h03, 8'h77);
      mvr(16'h0201, 8'h03, 8'h66);
      wr(`FWEC_ADDR_PSC, 8'h01);
      mv(16'h0201, 8'h00, 8'h01);
      `CHK("flash kept", 8'h12, fwec_device_inst.flash[14'h0201])
      `CHK("busy cycles", `FWEC_ERASE_CYCLES + `FWEC_WRITE_CYCLES, n_busy)
      ck(`FWEC_ADDR_KEY, 8'h03);
      wr(`FWEC_ADDR_KEY, `FWEC_KEY_FIRST);
      ck(`FWEC_ADDR_KEY, 8'h03);
      wr(`FWEC_ADDR_PSC, 8'h00);
      mv(16'h0300, 8'h11, 8'h01);
      mvr(16'h0300, 8'h03, 8'h11);
      rst;
      wr(`FWEC_ADDR_KEY, 8'h5a);
      ck(`FWEC_ADDR_KEY, 8'h03);
      `CHK("lock", FWEC_DEAD, lk)
      final_report;
   end
endmodule // flash_write_erase_control_tb_top
